// *** design/lcx_pkg.sv ***
// Constants, types and helpers for the load and transfer executor
package lcx_pkg;
  localparam logic [7:0] OP_BIT_COPY   = 8'h47;
  localparam logic [7:0] OP_IND_LD     = 8'hc3;
  localparam logic [7:0] OP_IND_ST     = 8'hd3;
  localparam logic [7:0] OP_XS_LD      = 8'he7;
  localparam logic [7:0] OP_XS_ST      = 8'hf7;
  localparam logic [7:0] OP_XL_LD      = 8'ha7;
  localparam logic [7:0] OP_XL_ST      = 8'hb7;
  localparam logic [7:0] OP_LD_POSTDEC = 8'he2;
  localparam logic [7:0] OP_LD_POSTINC = 8'he3;
  localparam logic [7:0] OP_ST_PREDEC  = 8'hf2;
  localparam logic [7:0] OP_ST_PREINC  = 8'hf3;
  localparam logic [7:0] OP_WORD_COPY  = 8'hc4;

  localparam logic [3:0] CYC_BIT   = 4'h6;
  localparam logic [3:0] CYC_IND   = 4'ha;
  localparam logic [3:0] CYC_XS    = 4'hc;
  localparam logic [3:0] CYC_XL    = 4'he;
  localparam logic [3:0] CYC_AUTO  = 4'ha;
  localparam logic [3:0] CYC_PRE   = 4'he;
  localparam logic [3:0] CYC_WORD  = 4'h8;
  localparam logic [3:0] CYC_NONE  = 4'h0;
  localparam logic [3:0] CNT_FIRST = 4'h1;
  localparam logic [3:0] CNT_MAX   = 4'hf;

  localparam int DIR_BIT      = 0;
  localparam int SPACE_BIT    = 0;
  localparam logic [2:0] DIRECT_PAIR = 3'h0;
  localparam logic SPACE_PROG = 1'b0;
  localparam logic SPACE_DATA = 1'b1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [2:0] {
    AM_PLAIN,
    AM_POST_DEC,
    AM_POST_INC,
    AM_PRE_DEC,
    AM_PRE_INC
  } lcx_mode_e;

  // Zero marks an opcode outside this group
  function automatic logic [3:0] lcx_cycles(input logic [7:0] op);
    case (op)
      OP_BIT_COPY:                  lcx_cycles = CYC_BIT;
      OP_IND_LD, OP_IND_ST:         lcx_cycles = CYC_IND;
      OP_XS_LD, OP_XS_ST:           lcx_cycles = CYC_XS;
      OP_XL_LD, OP_XL_ST:           lcx_cycles = CYC_XL;
      OP_LD_POSTDEC, OP_LD_POSTINC: lcx_cycles = CYC_AUTO;
      OP_ST_PREDEC, OP_ST_PREINC:   lcx_cycles = CYC_PRE;
      OP_WORD_COPY:                 lcx_cycles = CYC_WORD;
      default:                      lcx_cycles = CYC_NONE;
    endcase
  endfunction : lcx_cycles

  function automatic logic lcx_is_store(input logic [7:0] op);
    lcx_is_store = (op == OP_IND_ST) || (op == OP_XS_ST) || (op == OP_XL_ST) ||
                   (op == OP_ST_PREDEC) || (op == OP_ST_PREINC);
  endfunction : lcx_is_store

  // Even register of the pair addressed by a nibble
  function automatic logic [3:0] lcx_even(input logic [3:0] nib);
    lcx_even = {nib[3:1], 1'b0};
  endfunction : lcx_even
endpackage : lcx_pkg

// *** design/lcx_addr_if.sv ***
// Address request and answer between the executor and its address unit
`timescale 1ns/1ns
interface lcx_addr_if;
  import lcx_pkg::*;
  logic [15:0] pair;
  logic [15:0] offset;
  lcx_mode_e   mode;
  logic [15:0] eff;
  logic [15:0] new_pair;
  modport calc (input pair, offset, mode, output eff, new_pair);
  modport user (output pair, offset, mode, input eff, new_pair);
endinterface : lcx_addr_if

// *** design/lcx_addr_unit.sv ***
// Effective address and pair step arithmetic
`timescale 1ns/1ns
module lcx_addr_unit
  import lcx_pkg::*;
(
  // Address request
  lcx_addr_if.calc a
);
  function automatic logic [15:0] step(input logic [15:0] v, input logic up);
    step = up ? 16'(v + 16'h0001) : 16'(v - 16'h0001);
  endfunction : step

  always_comb begin
    a.eff      = 16'(a.pair + a.offset);
    a.new_pair = a.pair;
    case (a.mode)
      AM_POST_DEC: a.new_pair = step(a.pair, 1'b0);
      AM_POST_INC: a.new_pair = step(a.pair, 1'b1);
      AM_PRE_DEC: begin
        a.new_pair = step(a.pair, 1'b0);
        a.eff      = a.new_pair;
      end
      AM_PRE_INC: begin
        a.new_pair = step(a.pair, 1'b1);
        a.eff      = a.new_pair;
      end
      default: a.new_pair = a.pair;
    endcase
  end
endmodule : lcx_addr_unit

// *** design/lcx_bit_unit.sv ***
// Single-bit copy between two bytes
`timescale 1ns/1ns
module lcx_bit_unit
  import lcx_pkg::*;
(
  // Operands
  input  wire logic [7:0] dst_old,
  input  wire logic [7:0] src_old,
  input  wire logic [2:0] bit_sel,
  input  wire logic       dir,
  // Result for the destination
  output logic      [7:0] result
);
  always_comb begin
    result = dst_old;
    // Direction selects which side uses bit b
    if (!dir) begin
      result[0] = src_old[bit_sel];
    end else begin
      result[bit_sel] = src_old[0];
    end
  end
endmodule : lcx_bit_unit

// *** design/lcx_load_exec.sv ***
// Load and transfer instruction executor with working registers
`timescale 1ns/1ns
module lcx_load_exec
  import lcx_pkg::*;
#(
  parameter bit PROG_STORE_EN = 1'b1
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // Instruction from decode
  input  wire logic        INSTR_VALID,
  input  wire logic [31:0] INSTR_BYTES,
  output logic             INSTR_READY,
  output logic             DONE,
  output logic             ILLEGAL,
  // Memory port
  output logic             MEM_REQ,
  output logic             MEM_WE,
  output logic             MEM_SPACE,
  output logic      [15:0] MEM_ADDR,
  output logic       [7:0] MEM_WDATA,
  input  wire logic  [7:0] MEM_RDATA,
  input  wire logic        MEM_ACK,
  // Register view and flags
  input  wire logic  [3:0] RF_RADDR,
  output logic       [7:0] RF_RDATA,
  output logic             FLAGS_WRITE
);
  typedef enum logic {ST_IDLE, ST_EXEC} lcx_state_e;

  lcx_state_e  state_q, state_d;
  logic [3:0]  cnt_q, cnt_d, tot_q, tot_d;
  logic [7:0]  op_q, op_d, b1_q, b1_d, b2_q, b2_d, b3_q, b3_d;
  logic        ready_q, ready_d, done_q, done_d, ill_q, ill_d;
  logic        req_q, req_d, we_q, we_d, space_q, space_d, mdone_q, mdone_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0]  wdata_q, wdata_d, rdv_q, rdv_d;
  logic [7:0]  rf_q [16];
  logic        rf_we, pw_we;
  logic [3:0]  rf_waddr, pw_idx;
  logic [7:0]  rf_wdata;
  logic [15:0] pw_val;
  logic [3:0]  reg_nib, pair_nib, pidx, bit_dst, bit_src;
  logic        is_store, is_auto, is_direct, blocked;
  logic [7:0]  bit_res;
  lcx_addr_if  aif ();

  assign reg_nib  = b1_q[7:4];
  assign pair_nib = b1_q[3:0];
  assign pidx     = lcx_even(pair_nib);
  assign is_store = lcx_is_store(op_q);
  assign is_auto  = (op_q == OP_LD_POSTDEC) || (op_q == OP_LD_POSTINC) ||
                    (op_q == OP_ST_PREDEC) || (op_q == OP_ST_PREINC);
  // Pair zero-one in long forms means direct address
  assign is_direct = ((op_q == OP_XL_LD) || (op_q == OP_XL_ST)) && (pair_nib[3:1] == DIRECT_PAIR);
  // Program stores dropped on fixed-memory parts
  assign blocked  = is_store && (pair_nib[SPACE_BIT] == SPACE_PROG) && !PROG_STORE_EN;
  assign bit_dst  = b1_q[DIR_BIT] ? b2_q[3:0] : reg_nib;
  assign bit_src  = b1_q[DIR_BIT] ? reg_nib : b2_q[3:0];

  always_comb begin
    // Direct forms use a zero base
    aif.pair   = is_direct ? RST_WORD : {rf_q[pidx], rf_q[{pidx[3:1], 1'b1}]};
    aif.offset = RST_WORD;
    aif.mode   = AM_PLAIN;
    case (op_q)
      OP_XS_LD, OP_XS_ST: aif.offset = {8'h00, b2_q};
      OP_XL_LD, OP_XL_ST: aif.offset = {b3_q, b2_q};
      OP_LD_POSTDEC:      aif.mode = AM_POST_DEC;
      OP_LD_POSTINC:      aif.mode = AM_POST_INC;
      OP_ST_PREDEC:       aif.mode = AM_PRE_DEC;
      OP_ST_PREINC:       aif.mode = AM_PRE_INC;
      default:            aif.mode = AM_PLAIN;
    endcase
  end

  lcx_addr_unit u_addr (
    .a (aif.calc)
  );

  lcx_bit_unit u_bit (
    .dst_old (rf_q[bit_dst]),
    .src_old (rf_q[bit_src]),
    .bit_sel (b1_q[3:1]),
    .dir     (b1_q[DIR_BIT]),
    .result  (bit_res)
  );

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    tot_d    = tot_q;
    op_d     = op_q;
    b1_d     = b1_q;
    b2_d     = b2_q;
    b3_d     = b3_q;
    ready_d  = ready_q;
    done_d   = 1'b0;
    ill_d    = 1'b0;
    req_d    = req_q;
    we_d     = we_q;
    space_d  = space_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    mdone_d  = mdone_q;
    rf_we    = 1'b0;
    rf_waddr = 4'h0;
    rf_wdata = RST_BYTE;
    pw_we    = 1'b0;
    pw_idx   = 4'h0;
    pw_val   = RST_WORD;
    rdv_d    = rf_q[RF_RADDR];
    case (state_q)
      ST_IDLE: begin
        if (INSTR_VALID && ready_q) begin
          op_d  = INSTR_BYTES[7:0];
          b1_d  = INSTR_BYTES[15:8];
          b2_d  = INSTR_BYTES[23:16];
          b3_d  = INSTR_BYTES[31:24];
          tot_d = lcx_cycles(INSTR_BYTES[7:0]);
          if (lcx_cycles(INSTR_BYTES[7:0]) == CYC_NONE) begin
            ill_d = 1'b1;
          end else begin
            state_d = ST_EXEC;
            ready_d = 1'b0;
            cnt_d   = CNT_FIRST;
            mdone_d = 1'b0;
          end
        end
      end
      ST_EXEC: begin
        if (cnt_q != CNT_MAX) begin
          cnt_d = 4'(cnt_q + 4'h1);
        end
        if (cnt_q == CNT_FIRST) begin
          case (op_q)
            OP_BIT_COPY: begin
              rf_we    = 1'b1;
              rf_waddr = bit_dst;
              rf_wdata = bit_res;
              mdone_d  = 1'b1;
            end
            OP_WORD_COPY: begin
              pw_we   = 1'b1;
              pw_idx  = lcx_even(b2_q[3:0]);
              pw_val  = {rf_q[lcx_even(b1_q[3:0])], rf_q[{b1_q[3:1], 1'b1}]};
              mdone_d = 1'b1;
            end
            default: begin
              if (blocked) begin
                mdone_d = 1'b1;
              end else begin
                req_d   = 1'b1;
                we_d    = is_store;
                space_d = pair_nib[SPACE_BIT];
                addr_d  = aif.eff;
                wdata_d = rf_q[reg_nib];
              end
            end
          endcase
        end
        if (req_q && MEM_ACK) begin
          req_d   = 1'b0;
          mdone_d = 1'b1;
          if (!is_store) begin
            rf_we    = 1'b1;
            rf_waddr = reg_nib;
            rf_wdata = MEM_RDATA;
          end
          if (is_auto) begin
            pw_we  = 1'b1;
            pw_idx = pidx;
            pw_val = aif.new_pair;
          end
        end
        if ((cnt_q >= tot_q) && mdone_q) begin
          state_d = ST_IDLE;
          done_d  = 1'b1;
          ready_d = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      tot_q   <= CYC_NONE;
      op_q    <= RST_BYTE;
      b1_q    <= RST_BYTE;
      b2_q    <= RST_BYTE;
      b3_q    <= RST_BYTE;
      ready_q <= 1'b1;
      done_q  <= 1'b0;
      ill_q   <= 1'b0;
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      space_q <= SPACE_PROG;
      addr_q  <= RST_WORD;
      wdata_q <= RST_BYTE;
      mdone_q <= 1'b0;
      rdv_q   <= RST_BYTE;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      tot_q   <= tot_d;
      op_q    <= op_d;
      b1_q    <= b1_d;
      b2_q    <= b2_d;
      b3_q    <= b3_d;
      ready_q <= ready_d;
      done_q  <= done_d;
      ill_q   <= ill_d;
      req_q   <= req_d;
      we_q    <= we_d;
      space_q <= space_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      mdone_q <= mdone_d;
      rdv_q   <= rdv_d;
    end
  end

  // Pair write comes last so it wins over a byte write to the same register
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      for (int i = 0; i < 16; i++) begin
        rf_q[i] <= RST_BYTE;
      end
    end else begin
      if (rf_we) begin
        rf_q[rf_waddr] <= rf_wdata;
      end
      if (pw_we) begin
        rf_q[{pw_idx[3:1], 1'b0}] <= pw_val[15:8];
        rf_q[{pw_idx[3:1], 1'b1}] <= pw_val[7:0];
      end
    end
  end

  assign INSTR_READY = ready_q;
  assign DONE        = done_q;
  assign ILLEGAL     = ill_q;
  assign MEM_REQ     = req_q;
  assign MEM_WE      = we_q;
  assign MEM_SPACE   = space_q;
  assign MEM_ADDR    = addr_q;
  assign MEM_WDATA   = wdata_q;
  assign RF_RDATA    = rdv_q;
  assign FLAGS_WRITE = 1'b0;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  property p_bit_dir;
    rf_we && (op_q == OP_BIT_COPY) && !b1_q[DIR_BIT] |-> rf_wdata[0] == rf_q[bit_src][b1_q[3:1]];
  endproperty
  a_bit_dir: assert property (p_bit_dir) else $error("bit copy to bit zero wrong");

  property p_bit_only;
    rf_we && (op_q == OP_BIT_COPY) |-> $onehot0(rf_wdata ^ rf_q[bit_dst]);
  endproperty
  a_bit_only: assert property (p_bit_only) else $error("bit copy changed more than one bit");

  property p_ind_time;
    $rose(done_q) && (op_q == OP_IND_LD) |-> $past(cnt_q) >= CYC_IND;
  endproperty
  a_ind_time: assert property (p_ind_time) else $error("indirect load finished early");

  property p_space;
    $rose(req_q) |-> MEM_SPACE == pair_nib[SPACE_BIT];
  endproperty
  a_space: assert property (p_space) else $error("memory space not from pair parity");

  property p_xs_addr;
    $rose(req_q) && (op_q == OP_XS_LD) |-> MEM_ADDR == 16'($past(aif.pair) + {8'h00, b2_q});
  endproperty
  a_xs_addr: assert property (p_xs_addr) else $error("short index address wrong");

  property p_direct;
    $rose(req_q) && is_direct |-> MEM_ADDR == {b3_q, b2_q};
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");

  property p_rom_store;
    blocked && (state_q == ST_EXEC) |-> !req_q;
  endproperty
  a_rom_store: assert property (p_rom_store) else $error("program store on fixed part");

  property p_post_inc;
    pw_we && (op_q == OP_LD_POSTINC) |-> pw_val == 16'(aif.pair + 16'h0001);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post increment wrong");

  property p_pre_dec;
    $rose(req_q) && (op_q == OP_ST_PREDEC) |-> MEM_ADDR == 16'(aif.pair - 16'h0001) && MEM_WE;
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("pre decrement address wrong");

  property p_word;
    pw_we && (op_q == OP_WORD_COPY) |=> {rf_q[lcx_even(b2_q[3:0])], rf_q[{b2_q[3:1], 1'b1}]} == $past(pw_val);
  endproperty
  a_word: assert property (p_word) else $error("word copy wrong");

  property p_flags;
    state_q == ST_EXEC |-> !FLAGS_WRITE;
  endproperty
  a_flags: assert property (p_flags) else $error("flag write seen");

  c_bit: cover property ($rose(done_q) && op_q == OP_BIT_COPY);
  c_xl_store: cover property ($rose(req_q) && op_q == OP_XL_ST);
  c_auto: cover property (pw_we && op_q == OP_LD_POSTDEC);
endmodule : lcx_load_exec

// *** test/lcx_mem_model.sv ***
// Behavioural program and data memory facing the executor
`timescale 1ns/1ns
module lcx_mem_model (
  // Clock
  input  wire logic        clk,
  // Memory port
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic        sp,
  input  wire logic [15:0] addr,
  input  wire logic  [7:0] wdata,
  output logic       [7:0] rdata,
  output logic             ack,
  // Extra wait before answering
  input  wire logic  [2:0] dly
);
  logic [7:0] wr [logic [16:0]];
  logic [2:0] wait_q = 3'h0;
  initial begin
    ack   = 1'b0;
    rdata = 8'h5a;
  end
  // Unwritten cells hold a pattern of their address, so no preload is needed
  always @(posedge clk) begin
    if (ack) begin
      ack    <= 1'b0;
      rdata  <= ~rdata;
      wait_q <= 3'h0;
    end else if (req && wait_q >= dly) begin
      ack   <= 1'b1;
      rdata <= wr.exists({sp, addr}) ? wr[{sp, addr}] : addr[7:0] ^ addr[15:8] ^ (sp ? 8'h3c : 8'hc3);
      if (we)
        wr[{sp, addr}] = wdata;
    end else begin
      // Read data is never left looking valid between answers
      rdata <= rdata + 8'h35;
      if (req)
        wait_q <= wait_q + 3'h1;
    end
  end
endmodule : lcx_mem_model

// *** test/lcx_load_exec_tb_top.sv ***
// Self-checking bench for the load and transfer executor
`timescale 1ns/1ns
module lcx_load_exec_tb_top;
  import lcx_pkg::*;
  logic clock, sys_rst, instr_valid, instr_ready, done, illegal, flags_write;
  logic mem_req, mem_we, mem_space, mem_ack, rd_chk, rd_d;
  logic [31:0] instr_bytes;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata, mem_rdata, rf_rdata;
  logic [3:0]  rf_raddr;
  logic [2:0]  dly;
  logic [4:0]  cyc_cnt;
  logic [25:0] ea;
  logic [5:0]  ed;
  logic [7:0]  rf [16];
  logic [7:0]  shadow [logic [16:0]];
  logic [5:0]  q_done [$];
  logic [25:0] q_acc [$];
  logic [7:0]  q_reg [$];
  int fail_count = 0;
  int cmp_count = 0;
  int run_cyc = 0;

  lcx_load_exec #(.PROG_STORE_EN(1'b1)) i_lcx_load_exec (
    .CLOCK(clock), .SYS_RST(sys_rst), .INSTR_VALID(instr_valid), .INSTR_BYTES(instr_bytes),
    .INSTR_READY(instr_ready), .DONE(done), .ILLEGAL(illegal), .MEM_REQ(mem_req), .MEM_WE(mem_we),
    .MEM_SPACE(mem_space), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
    .MEM_ACK(mem_ack), .RF_RADDR(rf_raddr), .RF_RDATA(rf_rdata), .FLAGS_WRITE(flags_write));
  lcx_mem_model i_lcx_mem_model (
    .clk(clock), .req(mem_req), .we(mem_we), .sp(mem_space), .addr(mem_addr), .wdata(mem_wdata),
    .rdata(mem_rdata), .ack(mem_ack), .dly(dly));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string what, input logic [25:0] exp, input logic [25:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // Watcher: takes the oldest note whenever a result shows
  always @(posedge clock) begin
    run_cyc++;
    rd_d    <= rd_chk;
    cyc_cnt <= (instr_valid && instr_ready) ? 5'h00 : cyc_cnt + 5'h01;
    if (rd_d)
      check("register", q_reg.size() ? q_reg.pop_front() : 8'hxx, rf_rdata);
    if (mem_req && mem_ack) begin
      ea = q_acc.size() ? q_acc.pop_front() : 'x;
      check("access", ea, {mem_we, mem_space, mem_addr, mem_we ? mem_wdata : 8'h00});
    end
    if (done || illegal) begin
      ed = q_done.size() ? q_done.pop_front() : 'x;
      check("illegal", ed[5], illegal);
      // All ones marks a run whose length depends on memory wait
      if (ed[4:0] != 5'h1f)
        check("cycles", ed[4:0], cyc_cnt);
      check("flag write", 1'b0, flags_write);
    end
    if (run_cyc == 20000) begin
      fail_count++;
      $display("[FAIL] timeout expected completion seen hang");
      give_verdict();
    end
  end

  function automatic logic [7:0] mv(input logic s, input logic [15:0] a);
    return shadow.exists({s, a}) ? shadow[{s, a}] : a[7:0] ^ a[15:8] ^ (s ? 8'h3c : 8'hc3);
  endfunction : mv

  function automatic logic [15:0] pv(input logic [3:0] p);
    return {rf[{p[3:1], 1'b0}], rf[{p[3:1], 1'b1}]};
  endfunction : pv

  task automatic acc(input logic we, input logic s, input logic [15:0] a, input logic [7:0] d);
    q_acc.push_back({we, s, a, d});
    if (we)
      shadow[{s, a}] = d;
  endtask : acc

  task automatic exec(input logic [7:0] op, b1, b2, b3, input logic [4:0] n, input logic ill);
    int k;
    q_done.push_back({ill, n});
    k = 0;
    while (instr_ready !== 1'b1 && k < 50) begin
      @(posedge clock);
      #1 k++;
    end
    instr_bytes = {b3, b2, b1, op};
    instr_valid = 1'b1;
    @(posedge clock);
    #1 instr_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && illegal !== 1'b1 && k < 64) begin
      @(posedge clock);
      #1 k++;
    end
    check("done or illegal", 1'b1, done | illegal);
    // One spare edge so the next request never rises in this time step
    @(posedge clock);
    #1;
  endtask : exec

  task automatic set_reg(input logic [3:0] e, input logic [7:0] v);
    logic [15:0] a;
    a = {8'h00, v ^ 8'hc3};
    acc(1'b0, 1'b0, a, 8'h00);
    exec(8'ha7, {e, 4'h0}, a[7:0], 8'h00, 5'd14, 1'b0);
    rf[e] = mv(1'b0, a);
  endtask : set_reg

  task automatic chk_regs(input string name);
    for (int i = 0; i < 16; i++) begin
      rf_raddr = i[3:0];
      rd_chk   = 1'b1;
      q_reg.push_back(rf[i]);
      @(posedge clock);
      #1;
    end
    rd_chk = 1'b0;
    repeat (2) @(posedge clock);
    #1 $display("test %s finished", name);
  endtask : chk_regs

  initial begin
    logic [3:0]  p, r, o;
    logic [15:0] a, off;
    logic [7:0]  op;
    logic        sp;
    logic [7:0]  ix_ops [4] = '{8'he7, 8'hf7, 8'ha7, 8'hb7};
    logic [7:0]  au_ops [4] = '{8'he2, 8'he3, 8'hf2, 8'hf3};
    logic [7:0]  bad_ops [4] = '{8'h00, 8'hff, 8'hc5, 8'h87};
    void'($urandom(32'hd5b7));
    {sys_rst, instr_valid, instr_bytes, rf_raddr, rd_chk, dly} = {1'b1, 1'b0, 32'h0, 4'h0, 1'b0, 3'h0};
    rf = '{default: 8'h00};
    repeat (4) @(posedge clock);
    #1 sys_rst = 1'b0;
    check("ready", 1'b1, instr_ready);
    chk_regs("reset");
    for (int i = 0; i < 16; i++) begin
      sp = 1'($urandom);
      a  = 16'($urandom);
      acc(1'b0, sp, a, 8'h00);
      exec(8'ha7, {i[3:0], 3'h0, sp}, a[7:0], a[15:8], 5'd14, 1'b0);
      rf[i] = mv(sp, a);
      acc(1'b1, sp, ~a, rf[i]);
      exec(8'hb7, {i[3:0], 3'h0, sp}, ~a[7:0], ~a[15:8], 5'd14, 1'b0);
    end
    chk_regs("direct");
    for (int i = 0; i < 12; i++) begin
      p   = 4'(2 + $urandom % 14);
      r   = {p[3:1] ^ 3'h4, 1'($urandom)};
      dly = 3'($urandom % 4);
      a   = pv(p);
      acc(i[0], p[0], a, i[0] ? rf[r] : 8'h00);
      exec(i[0] ? 8'hd3 : 8'hc3, {r, p}, 8'h00, 8'h00, dly != 3'h0 ? 5'h1f : 5'h0a, 1'b0);
      if (!i[0])
        rf[r] = mv(p[0], a);
    end
    dly = 3'h0;
    chk_regs("indirect");
    for (int i = 0; i < 12; i++) begin
      op  = ix_ops[i % 4];
      p   = 4'(2 + $urandom % 14);
      r   = {p[3:1] ^ 3'h4, 1'($urandom)};
      set_reg({p[3:1], 1'b0}, 8'hff);
      off = 16'($urandom);
      if (op[6])
        off[15:8] = 8'h00;
      a = pv(p) + off;
      acc(op[4], p[0], a, op[4] ? rf[r] : 8'h00);
      exec(op, {r, p}, off[7:0], off[15:8], op[6] ? 5'd12 : 5'd14, 1'b0);
      if (!op[4])
        rf[r] = mv(p[0], a);
    end
    chk_regs("indexed");
    for (int i = 0; i < 8; i++) begin
      op = au_ops[i % 4];
      p  = 4'(2 + $urandom % 14);
      r  = {p[3:1] ^ 3'h4, 1'($urandom)};
      set_reg({p[3:1], 1'b1}, i < 4 ? 8'h00 : 8'hff);
      a = pv(p);
      if (op[4])
        a = op[0] ? a + 16'h1 : a - 16'h1;
      acc(op[4], p[0], a, op[4] ? rf[r] : 8'h00);
      exec(op, {r, p}, 8'h00, 8'h00, op[4] ? 5'd14 : 5'd10, 1'b0);
      if (!op[4]) begin
        rf[r] = mv(p[0], a);
        a = op[0] ? a + 16'h1 : a - 16'h1;
      end
      {rf[{p[3:1], 1'b0}], rf[{p[3:1], 1'b1}]} = a;
    end
    chk_regs("auto step");
    for (int i = 0; i < 16; i++) begin
      r = 4'($urandom);
      o = r ^ 4'(1 + $urandom % 15);
      exec(8'h47, {r, i[3:1], i[0]}, {4'h0, o}, 8'h00, 5'd6, 1'b0);
      if (i[0])
        rf[o][i[3:1]] = rf[r][0];
      else
        rf[r][0] = rf[o][i[3:1]];
    end
    chk_regs("bit copy");
    for (int i = 0; i < 4; i++) begin
      p = 4'(2 + $urandom % 14);
      o = {p[3:1] ^ 3'h3, 1'b0};
      exec(8'hc4, {4'h0, p[3:1], 1'b0}, {4'h0, o}, 8'h00, 5'd8, 1'b0);
      {rf[o], rf[{o[3:1], 1'b1}]} = pv(p);
    end
    chk_regs("word copy");
    foreach (bad_ops[i])
      exec(bad_ops[i], 8'h12, 8'h34, 8'h56, 5'h00, 1'b1);
    chk_regs("outside group");
    // Every note must have met its result
    check("pending notes", 26'h0, 26'(q_done.size() + q_acc.size() + q_reg.size()));
    give_verdict();
  end
endmodule : lcx_load_exec_tb_top
